// ### lce_pkg.sv
// Package with attribute encodings for the coherent-lite request encoder
package lce_pkg;

    // ------------------------------------------------------------------
    // Domain encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] LCE_DOM_NONSH = 2'h0;
    localparam logic [1:0] LCE_DOM_INNER = 2'h1;
    localparam logic [1:0] LCE_DOM_OUTER = 2'h2;
    localparam logic [1:0] LCE_DOM_SYS = 2'h3;

    // ------------------------------------------------------------------
    // Snoop type encodings
    // ------------------------------------------------------------------
    localparam logic [3:0] LCE_RSNP_PLAIN = 4'h0;
    localparam logic [3:0] LCE_RSNP_CLEAN_KEEP = 4'h8;
    localparam logic [3:0] LCE_RSNP_CLEAN_DROP = 4'h9;
    localparam logic [3:0] LCE_RSNP_DROP = 4'hD;
    localparam logic [2:0] LCE_WSNP_PLAIN = 3'h0;
    localparam logic [2:0] LCE_WSNP_FULL_LINE = 3'h1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] LCE_RSNP_RST = 4'h0;
    localparam logic [2:0] LCE_WSNP_RST = 3'h0;
    localparam logic [1:0] LCE_DOM_RST = 2'h0;

    // ------------------------------------------------------------------
    // Request kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LCE_RD_PLAIN,
        LCE_RD_SINGLE_COHERENT,
        LCE_RD_CLEAN_KEEP_COPIES,
        LCE_RD_CLEAN_THEN_DROP,
        LCE_RD_DROP_WITHOUT_CLEAN,
        LCE_RD_BARRIER
    } lce_rd_kind_e;

    typedef enum logic [1:0] {
        LCE_WR_PLAIN,
        LCE_WR_COHERENT_PARTIAL,
        LCE_WR_COHERENT_FULL_LINE,
        LCE_WR_BARRIER
    } lce_wr_kind_e;

    // ------------------------------------------------------------------
    // Attribute carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] read_snoop_type;
        logic read_barrier_flag;
        logic [1:0] read_share_domain;
    } lce_rd_attr_s;

    typedef struct packed {
        logic [2:0] write_snoop_type;
        logic write_barrier_flag;
        logic [1:0] write_share_domain;
    } lce_wr_attr_s;

endpackage

// ### lce_encoder.sv
// Coherent-lite request attribute encoder and checker
`timescale 1ns/1ps
`default_nettype none

module lce_encoder
    import lce_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Read request from requester core
    input wire logic rd_req_valid_i,
    input wire lce_rd_kind_e rd_kind_i,
    input wire logic [1:0] rd_domain_i,
    output logic rd_req_ready_o,
    // Write request from requester core
    input wire logic wr_req_valid_i,
    input wire lce_wr_kind_e wr_kind_i,
    input wire logic [1:0] wr_domain_i,
    output logic wr_req_ready_o,
    // Read request channel toward interconnect
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output lce_rd_attr_s rd_attr_o,
    // Write request channel toward interconnect
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output lce_wr_attr_s wr_attr_o,
    // Illegal request seen and dropped
    output logic rd_illegal_o,
    output logic wr_illegal_o
);

    // ------------------------------------------------------------------
    // Read domain classes
    // ------------------------------------------------------------------
    wire logic dom_nonsh_sys;
    wire logic dom_shared;
    wire logic dom_not_sys;

    assign dom_nonsh_sys = (rd_domain_i == LCE_DOM_NONSH) ||
                           (rd_domain_i == LCE_DOM_SYS);
    assign dom_shared = (rd_domain_i == LCE_DOM_INNER) ||
                        (rd_domain_i == LCE_DOM_OUTER);
    assign dom_not_sys = rd_domain_i != LCE_DOM_SYS;

    // ------------------------------------------------------------------
    // Read attribute encode and legality
    // ------------------------------------------------------------------
    logic [3:0] rd_snp;
    logic rd_bar;
    logic rd_legal;
    always_comb begin
        rd_snp = LCE_RSNP_PLAIN;
        rd_bar = 1'b0;
        rd_legal = 1'b0;
        unique case (rd_kind_i)
            LCE_RD_PLAIN: begin
                rd_legal = dom_nonsh_sys;
            end
            LCE_RD_SINGLE_COHERENT: begin
                rd_legal = dom_shared;
            end
            LCE_RD_CLEAN_KEEP_COPIES: begin
                rd_snp = LCE_RSNP_CLEAN_KEEP;
                rd_legal = dom_not_sys;
            end
            LCE_RD_CLEAN_THEN_DROP: begin
                rd_snp = LCE_RSNP_CLEAN_DROP;
                rd_legal = dom_not_sys;
            end
            LCE_RD_DROP_WITHOUT_CLEAN: begin
                rd_snp = LCE_RSNP_DROP;
                rd_legal = dom_not_sys;
            end
            LCE_RD_BARRIER: begin
                rd_bar = 1'b1;
                rd_legal = 1'b1;
            end
            default: begin
                // Unused kind codes are refused
                rd_legal = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Write domain classes
    // ------------------------------------------------------------------
    wire logic wdom_nonsh_sys;
    wire logic wdom_shared;

    assign wdom_nonsh_sys = (wr_domain_i == LCE_DOM_NONSH) ||
                            (wr_domain_i == LCE_DOM_SYS);
    assign wdom_shared = (wr_domain_i == LCE_DOM_INNER) ||
                         (wr_domain_i == LCE_DOM_OUTER);

    // ------------------------------------------------------------------
    // Write attribute encode and legality
    // ------------------------------------------------------------------
    logic [2:0] wr_snp;
    logic wr_bar;
    logic wr_legal;
    always_comb begin
        wr_snp = LCE_WSNP_PLAIN;
        wr_bar = 1'b0;
        wr_legal = 1'b0;
        unique case (wr_kind_i)
            LCE_WR_PLAIN: begin
                wr_legal = wdom_nonsh_sys;
            end
            LCE_WR_COHERENT_PARTIAL: begin
                wr_legal = wdom_shared;
            end
            LCE_WR_COHERENT_FULL_LINE: begin
                wr_snp = LCE_WSNP_FULL_LINE;
                wr_legal = wdom_shared;
            end
            LCE_WR_BARRIER: begin
                wr_bar = 1'b1;
                wr_legal = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------------
    // Illegal requests are consumed and flagged, never forwarded
    wire logic rd_take;
    wire logic wr_take;
    wire logic rd_load;
    wire logic wr_load;
    wire logic rd_drop;
    wire logic wr_drop;

    assign rd_take = rd_req_valid_i && rd_req_ready_o;
    assign rd_load = rd_take && rd_legal;
    assign rd_drop = rd_take && !rd_legal;

    assign wr_take = wr_req_valid_i && wr_req_ready_o;
    assign wr_load = wr_take && wr_legal;
    assign wr_drop = wr_take && !wr_legal;

    // ------------------------------------------------------------------
    // Held request tracking
    // ------------------------------------------------------------------
    // Ready is registered, so it drops whenever a request will be held;
    // a take can then never land on a request still waiting for ready
    wire logic next_rd_valid;
    wire logic next_wr_valid;
    wire logic next_rd_ready;
    wire logic next_wr_ready;

    assign next_rd_valid = rd_load || (rd_valid_o && !rd_ready_i);
    assign next_rd_ready = !next_rd_valid;

    assign next_wr_valid = wr_load || (wr_valid_o && !wr_ready_i);
    assign next_wr_ready = !next_wr_valid;

    // ------------------------------------------------------------------
    // Attribute words
    // ------------------------------------------------------------------
    // Field order is snoop type, barrier flag, domain
    wire lce_rd_attr_s next_rd_attr;
    wire lce_wr_attr_s next_wr_attr;

    assign next_rd_attr = '{rd_snp, rd_bar, rd_domain_i};
    assign next_wr_attr = '{wr_snp, wr_bar, wr_domain_i};

    // ------------------------------------------------------------------
    // Read request channel register; no snoop channels exist
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_attr_o <= '{LCE_RSNP_RST, 1'b0, LCE_DOM_RST};
            rd_illegal_o <= 1'b0;
            rd_req_ready_o <= 1'b0;
        end else begin
            rd_valid_o <= next_rd_valid;
            rd_req_ready_o <= next_rd_ready;
            rd_illegal_o <= rd_drop;
            if (rd_load) begin
                rd_attr_o <= next_rd_attr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write request channel register; no acknowledge outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_valid_o <= 1'b0;
            wr_attr_o <= '{LCE_WSNP_RST, 1'b0, LCE_DOM_RST};
            wr_illegal_o <= 1'b0;
            wr_req_ready_o <= 1'b0;
        end else begin
            wr_valid_o <= next_wr_valid;
            wr_req_ready_o <= next_wr_ready;
            wr_illegal_o <= wr_drop;
            if (wr_load) begin
                wr_attr_o <= next_wr_attr;
            end
        end
    end

endmodule

`default_nettype wire

// ### lce_encoder_properties.sv
// Concurrent checks on the request encoder ports
`timescale 1ns/1ps
`default_nettype none
module lce_encoder_checker
    import lce_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic rd_req_valid_i,
    input wire lce_rd_kind_e rd_kind_i,
    input wire logic [1:0] rd_domain_i,
    input wire logic rd_req_ready_o,
    input wire logic wr_req_valid_i,
    input wire lce_wr_kind_e wr_kind_i,
    input wire logic [1:0] wr_domain_i,
    input wire logic wr_req_ready_o,
    input wire logic rd_valid_o,
    input wire logic rd_ready_i,
    input wire lce_rd_attr_s rd_attr_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire lce_wr_attr_s wr_attr_o,
    input wire logic rd_illegal_o,
    input wire logic wr_illegal_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire rd_take = rd_req_valid_i && rd_req_ready_o;
    wire wr_take = wr_req_valid_i && wr_req_ready_o;
    wire rd_ok = rd_attr_o[6:3] == 4'h0 ||
        (rd_attr_o[2:0] < 3'h3 && rd_attr_o[6:3] inside {4'h8, 4'h9, 4'hD});
    wire wr_ok = wr_attr_o[5:3] == 3'h0 ||
        (wr_attr_o[5:3] == 3'h1 && wr_attr_o[2:0] inside {3'h1, 3'h2});
    AST_RD_LEGAL: assert property (rd_valid_o |-> rd_ok)
        else $error("bad read attributes");
    AST_WR_LEGAL: assert property (wr_valid_o |-> wr_ok)
        else $error("bad write attributes");
    AST_RD_HOLD: assert property (rd_valid_o && !rd_ready_i |=>
        rd_valid_o && $stable(rd_attr_o)) else $error("read not held");
    AST_WR_HOLD: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_attr_o)) else $error("write not held");
    AST_RD_ANS: assert property (
        rd_take |=> rd_valid_o != rd_illegal_o) else $error("read answer");
    AST_WR_ANS: assert property (
        wr_take |=> wr_valid_o != wr_illegal_o) else $error("write answer");
    AST_RD_BAR: assert property (rd_take && rd_kind_i == LCE_RD_BARRIER
        |=> rd_valid_o && rd_attr_o == {4'h0, 1'b1, $past(rd_domain_i)})
        else $error("read barrier attributes");
    AST_WR_FULL: assert property (wr_take && wr_domain_i inside {2'h1,
        2'h2} && wr_kind_i == LCE_WR_COHERENT_FULL_LINE |=> wr_valid_o
        && wr_attr_o == {3'h1, 1'b0, $past(wr_domain_i)})
        else $error("full line write attributes");
endmodule
bind lce_encoder lce_encoder_checker i_lce_encoder_checker (.sys_clk_i,
    .rst_n_i, .rd_req_valid_i, .rd_kind_i, .rd_domain_i, .rd_req_ready_o,
    .wr_req_valid_i, .wr_kind_i, .wr_domain_i, .wr_req_ready_o, .rd_valid_o,
    .rd_ready_i, .rd_attr_o, .wr_valid_o, .wr_ready_i, .wr_attr_o,
    .rd_illegal_o, .wr_illegal_o);
`default_nettype wire

// ### lce_ic_model.sv
// Interconnect stand-in that accepts requests and counts bad attributes
`timescale 1ns/1ps
`default_nettype none
module lce_ic_model
    import lce_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic rd_valid_i,
    input wire lce_rd_attr_s rd_attr_i,
    input wire logic wr_valid_i,
    input wire lce_wr_attr_s wr_attr_i,
    output logic rd_ready_o,
    output logic wr_ready_o,
    output int bad_o
);
    logic tick;
    wire rd_bad = rd_attr_i[6:3] != 4'h0 && (rd_attr_i[2:0] > 3'h2 ||
        !(rd_attr_i[6:3] inside {4'h8, 4'h9, 4'hD}));
    wire wr_bad = wr_attr_i[5:3] > 3'h1 || (wr_attr_i[5:3] == 3'h1 &&
        !(wr_attr_i[2:0] inside {3'h1, 3'h2}));
    assign rd_ready_o = !slow_i || tick;
    assign wr_ready_o = !slow_i || !tick;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick <= 1'b0;
            bad_o <= 0;
        end else begin
            tick <= ~tick;
            bad_o <= bad_o + int'(rd_valid_i && rd_ready_o && rd_bad)
                + int'(wr_valid_i && wr_ready_o && wr_bad);
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the request encoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lce_pkg::*;
    logic sys_clk_i, rst_n_i, slow, rd_req_valid_i, wr_req_valid_i;
    logic rd_ready_i, wr_ready_i, rd_req_ready_o, wr_req_ready_o;
    logic rd_valid_o, wr_valid_o, rd_illegal_o, wr_illegal_o;
    logic [1:0] rd_domain_i, wr_domain_i;
    lce_rd_kind_e rd_kind_i;
    lce_wr_kind_e wr_kind_i;
    lce_rd_attr_s rd_attr_o;
    lce_wr_attr_s wr_attr_o;
    int err_count = 0, n_checks = 0, cycles = 0, bad;
    lce_encoder i_lce_encoder (.sys_clk_i, .rst_n_i, .rd_req_valid_i,
        .rd_kind_i, .rd_domain_i, .rd_req_ready_o, .wr_req_valid_i,
        .wr_kind_i, .wr_domain_i, .wr_req_ready_o, .rd_valid_o, .rd_ready_i,
        .rd_attr_o, .wr_valid_o, .wr_ready_i, .wr_attr_o, .rd_illegal_o,
        .wr_illegal_o);
    lce_ic_model i_lce_ic_model (.sys_clk_i, .rst_n_i, .slow_i(slow),
        .rd_valid_i(rd_valid_o), .rd_attr_i(rd_attr_o), .rd_ready_o(rd_ready_i),
        .wr_valid_i(wr_valid_o), .wr_attr_i(wr_attr_o), .wr_ready_o(wr_ready_i),
        .bad_o(bad));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end
    // One read: present until taken, then judge the answer cycle
    task automatic rd(lce_rd_kind_e k, logic [1:0] d, logic ok, logic [3:0] s);
        rd_req_valid_i <= 1'b1;
        rd_kind_i <= k;
        rd_domain_i <= d;
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk_i);
            if (rd_req_ready_o === 1'b1) break;
        end
        rd_req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        chk({rd_valid_o, rd_illegal_o}, {ok, !ok});
        chk(rd_req_ready_o, !ok);
        if (ok) chk(rd_attr_o, {s, k == LCE_RD_BARRIER, d});
    endtask
    task automatic wr(lce_wr_kind_e k, logic [1:0] d, logic ok, logic [2:0] s);
        wr_req_valid_i <= 1'b1;
        wr_kind_i <= k;
        wr_domain_i <= d;
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk_i);
            if (wr_req_ready_o === 1'b1) break;
        end
        wr_req_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        chk({wr_valid_o, wr_illegal_o}, {ok, !ok});
        chk(wr_req_ready_o, !ok);
        if (ok) chk(wr_attr_o, {s, k == LCE_WR_BARRIER, d});
    endtask
    task automatic test_reads();
        rd(LCE_RD_PLAIN, 2'h3, 1'b1, 4'h0);
        rd(LCE_RD_PLAIN, 2'h1, 1'b0, 4'h0);
        rd(LCE_RD_SINGLE_COHERENT, 2'h2, 1'b1, 4'h0);
        rd(LCE_RD_SINGLE_COHERENT, 2'h0, 1'b0, 4'h0);
        rd(LCE_RD_CLEAN_KEEP_COPIES, 2'h0, 1'b1, 4'h8);
        rd(LCE_RD_CLEAN_KEEP_COPIES, 2'h3, 1'b0, 4'h8);
        rd(LCE_RD_CLEAN_THEN_DROP, 2'h1, 1'b1, 4'h9);
        rd(LCE_RD_DROP_WITHOUT_CLEAN, 2'h2, 1'b1, 4'hD);
        rd(LCE_RD_DROP_WITHOUT_CLEAN, 2'h3, 1'b0, 4'hD);
        rd(LCE_RD_BARRIER, 2'h3, 1'b1, 4'h0);
    endtask
    // Writes and a closing read barrier against a stalling interconnect
    task automatic test_writes();
        slow <= 1'b1;
        wr(LCE_WR_PLAIN, 2'h0, 1'b1, 3'h0);
        wr(LCE_WR_PLAIN, 2'h2, 1'b0, 3'h0);
        wr(LCE_WR_COHERENT_PARTIAL, 2'h1, 1'b1, 3'h0);
        wr(LCE_WR_COHERENT_FULL_LINE, 2'h2, 1'b1, 3'h1);
        wr(LCE_WR_COHERENT_FULL_LINE, 2'h3, 1'b0, 3'h1);
        wr(LCE_WR_BARRIER, 2'h0, 1'b1, 3'h0);
        rd(LCE_RD_BARRIER, 2'h1, 1'b1, 4'h0);
    endtask
    initial begin
        {rst_n_i, slow, rd_req_valid_i, wr_req_valid_i} = 4'h0;
        {rd_domain_i, wr_domain_i} = 4'h0;
        rd_kind_i = LCE_RD_PLAIN;
        wr_kind_i = LCE_WR_PLAIN;
        repeat (5) @(posedge sys_clk_i);
        chk({rd_req_ready_o, wr_req_ready_o, rd_valid_o, wr_valid_o,
            rd_illegal_o, wr_illegal_o, rd_attr_o, wr_attr_o}, 32'h0);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        test_reads();
        test_writes();
        chk(bad, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
